// ==== hw/vocoder_frame_cfg.svh ====
// Numeric constants for the vocoder frame octet packer
`ifndef VOCODER_FRAME_CFG_SVH
`define VOCODER_FRAME_CFG_SVH

`define CNT_W           7
`define OCT_W           8
`define IDX_W           4
`define LEFT_W          4
`define FRAME_BITS_2400 7'h36
`define FRAME_BITS_1200 7'h51
`define OCTETS_2400     4'h7
`define OCTETS_1200     4'hB
`define OCTET_BITS      7'h08
`define OCTET_BITS_L    4'h8
`define OCT_POS_LAST    3'h7
`define SYNC_POS        3'h5
`define CNT_ZERO        7'h00
`define CNT_ONE         7'h01
`define POS_ZERO        3'h0
`define POS_ONE         3'h1
`define IDX_ZERO        4'h0
`define IDX_ONE         4'h1
`define LEFT_ONE        4'h1
`define OCT_ZERO        8'h00

`endif

// ==== hw/vocoder_frame_pkg.sv ====
// Types and shared decoding for the vocoder frame octet packer
package vocoder_frame_pkg;
  `include "vocoder_frame_cfg.svh"

  typedef enum logic {RATE_2400, RATE_1200} rate_type;
  typedef enum logic [1:0] {PACK_FILL, PACK_HOLD} pack_state_type;
  typedef enum logic [1:0] {UNP_WAIT, UNP_SHIFT} unp_state_type;

  // Information bits in one frame at the given rate
  function automatic logic [`CNT_W-1:0] frame_bits(input rate_type rate);
    frame_bits = (rate == RATE_2400) ? `FRAME_BITS_2400 : `FRAME_BITS_1200;
  endfunction : frame_bits

  // Octets taken by one frame at the given rate
  function automatic logic [`IDX_W-1:0] frame_octets(input rate_type rate);
    frame_octets = (rate == RATE_2400) ? `OCTETS_2400 : `OCTETS_1200;
  endfunction : frame_octets
endpackage : vocoder_frame_pkg

// ==== hw/frame_unpacker.sv ====
// Octet stream to serial frame bit unpacker
`timescale 1ns/1ps
`include "vocoder_frame_cfg.svh"

module frame_unpacker (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire vocoder_frame_pkg::rate_type rx_rate_sel,
  input  wire logic [`OCT_W-1:0]          rx_octet,
  input  wire logic                       rx_octet_valid,
  output logic                            rx_octet_ready,
  output logic                            rx_bit,
  output logic                            rx_bit_valid,
  input  wire logic                       rx_bit_ready,
  output logic                            rx_bit_last,
  output logic                            rx_frame_valid,
  output logic                            rx_sync_err
);
  import vocoder_frame_pkg::*;

  unp_state_type          state_r;
  logic [`OCT_W-1:0]      sh_r;
  logic [`LEFT_W-1:0]     left_r;
  logic                   last_oct_r;
  logic [`CNT_W-1:0]      bit_cnt_r;
  rate_type               rate_r;
  rate_type               rate_cur;
  logic [`CNT_W-1:0]      rem;
  logic                   last_oct;
  logic [`LEFT_W-1:0]     take;
  logic                   accept;
  logic                   shift;
  logic                   sync_prev_r;
  logic                   sync_seen_r;
  logic                   sync_bit;

  // ---------------------------------------------------------------
  // Octet intake
  // ---------------------------------------------------------------
  assign rx_octet_ready = (state_r == UNP_WAIT);
  assign accept         = rx_octet_ready && rx_octet_valid;
  assign rate_cur       = (bit_cnt_r == `CNT_ZERO) ? rx_rate_sel : rate_r;
  assign rem            = frame_bits(rate_cur) - bit_cnt_r;
  assign last_oct       = (rem <= `OCTET_BITS);
  // Pad positions above the count are never shifted out
  assign take           = last_oct ? rem[`LEFT_W-1:0] : `OCTET_BITS_L;
  assign shift          = (state_r == UNP_SHIFT) && rx_bit_ready;
  assign sync_bit       = rx_octet[`SYNC_POS];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= UNP_WAIT;
    end else begin
      unique case (state_r)
        UNP_WAIT:  if (accept) state_r <= UNP_SHIFT;
        UNP_SHIFT: if (shift && left_r == `LEFT_ONE) state_r <= UNP_WAIT;
        default:   state_r <= UNP_WAIT;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bit_cnt_r <= `CNT_ZERO;
      rate_r    <= RATE_2400;
    end else if (accept) begin
      // Every frame restarts at a fresh octet
      bit_cnt_r <= last_oct ? `CNT_ZERO : bit_cnt_r + `OCTET_BITS;
      rate_r    <= rate_cur;
    end
  end

  // ---------------------------------------------------------------
  // Serial bit delivery, LSB first
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sh_r       <= `OCT_ZERO;
      left_r     <= `LEFT_W'(0);
      last_oct_r <= 1'b0;
    end else if (accept) begin
      sh_r       <= rx_octet;
      left_r     <= take;
      last_oct_r <= last_oct;
    end else if (shift) begin
      sh_r       <= {1'b0, sh_r[`OCT_W-1:1]};
      left_r     <= left_r - `LEFT_ONE;
    end
  end

  assign rx_bit       = sh_r[0];
  assign rx_bit_valid = (state_r == UNP_SHIFT);
  assign rx_bit_last  = last_oct_r && (left_r == `LEFT_ONE);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_frame_valid <= 1'b0;
    end else begin
      rx_frame_valid <= accept && last_oct;
    end
  end

  // ---------------------------------------------------------------
  // Alternation of the final bit of a 2400 frame
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_prev_r <= 1'b0;
      sync_seen_r <= 1'b0;
      rx_sync_err <= 1'b0;
    end else begin
      rx_sync_err <= 1'b0;
      if (accept && last_oct && rate_cur == RATE_2400) begin
        sync_prev_r <= sync_bit;
        sync_seen_r <= 1'b1;
        rx_sync_err <= sync_seen_r && (sync_bit == sync_prev_r);
      end
    end
  end
endmodule : frame_unpacker

// ==== hw/vocoder_frame_octet_packer.sv ====
// Vocoder frame octet packer with its receive-side unpacker
`timescale 1ns/1ps
`include "vocoder_frame_cfg.svh"

// Summary of operation
// - each frame starts in a fresh octet whatever the previous length was.
// - inside an octet earlier frame bits sit in lower positions.
// - frame bit one lands in the LSB of the frame's first octet.
// - a 54-bit frame at 2400 bit/s fills exactly seven octets.
// - an 81-bit frame at 1200 bit/s fills exactly eleven octets.
// - leftover positions lie only at the top of the final octet.
// - at 2400 the seventh octet holds bits 49-54, two pad bits above.
// - at 1200 the eleventh octet holds bit 81, seven pad bits above.
// - the packer sends every pad bit as zero.
// - the unpacker ignores pad bit values entirely.
// - bit n goes to octet (n-1)/8+1, bit position (n-1) mod 8 with the LSB as zero.
// - the final 2400 frame bit alternates between zero and one; a repeat is only flagged on tx_sync_err and rx_sync_err.
// - a 2400 frame is always 54 bits, bit one first, 54 last.
module vocoder_frame_octet_packer (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire vocoder_frame_pkg::rate_type tx_rate_sel,
  input  wire logic                        tx_bit,
  input  wire logic                        tx_bit_valid,
  output logic                             tx_bit_ready,
  output logic [`OCT_W-1:0]                tx_octet,
  output logic [`IDX_W-1:0]                tx_octet_index,
  output logic                             tx_octet_valid,
  input  wire logic                        tx_octet_ready,
  output logic                             tx_octet_last,
  output logic                             tx_sync_err,
  input  wire vocoder_frame_pkg::rate_type rx_rate_sel,
  input  wire logic [`OCT_W-1:0]           rx_octet,
  input  wire logic                        rx_octet_valid,
  output logic                             rx_octet_ready,
  output logic                             rx_bit,
  output logic                             rx_bit_valid,
  input  wire logic                        rx_bit_ready,
  output logic                             rx_bit_last,
  output logic                             rx_frame_valid,
  output logic                             rx_sync_err
);
  import vocoder_frame_pkg::*;

  pack_state_type         state_r;
  logic [`OCT_W-1:0]      acc_r;
  logic [2:0]             pos_r;
  logic [`CNT_W-1:0]      bit_cnt_r;
  logic [`IDX_W-1:0]      idx_r;
  rate_type               rate_r;
  rate_type               rate_cur;
  logic                   take_bit;
  logic                   frame_end;
  logic                   octet_full;
  logic [`OCT_W-1:0]      acc_with_bit;
  logic                   pop;
  logic                   sync_prev_r;
  logic                   sync_seen_r;

  // ---------------------------------------------------------------
  // Bit intake
  // ---------------------------------------------------------------
  // One octet of staging only: the source stalls while an octet
  // waits, trading throughput for a small footprint.
  assign tx_bit_ready = (state_r == PACK_FILL);
  assign take_bit     = tx_bit_ready && tx_bit_valid;
  // Rate is sampled on the first bit and held for the frame
  assign rate_cur     = (bit_cnt_r == `CNT_ZERO) ? tx_rate_sel : rate_r;
  // Frame length is fixed by rate
  assign frame_end    = (bit_cnt_r == frame_bits(rate_cur) - `CNT_ONE);
  assign octet_full   = (pos_r == `OCT_POS_LAST);
  assign pop          = tx_octet_valid && tx_octet_ready;

  // Place the new bit at its position, LSB first
  always_comb begin
    acc_with_bit        = acc_r;
    acc_with_bit[pos_r] = tx_bit;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= PACK_FILL;
    end else begin
      unique case (state_r)
        PACK_FILL: if (take_bit && (octet_full || frame_end)) begin
          state_r <= PACK_HOLD;
        end
        PACK_HOLD: if (pop) state_r <= PACK_FILL;
        default:   state_r <= PACK_FILL;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bit_cnt_r <= `CNT_ZERO;
      rate_r    <= RATE_2400;
    end else if (take_bit) begin
      bit_cnt_r <= frame_end ? `CNT_ZERO : bit_cnt_r + `CNT_ONE;
      rate_r    <= rate_cur;
    end
  end

  // Position resets at frame end so the next frame starts aligned
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pos_r <= `POS_ZERO;
    end else if (take_bit) begin
      pos_r <= frame_end ? `POS_ZERO : pos_r + `POS_ONE;
    end
  end

  // Accumulator clears after each octet, so unused high positions
  // of the final octet are zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_r <= `OCT_ZERO;
    end else if (take_bit) begin
      acc_r <= (octet_full || frame_end) ? `OCT_ZERO : acc_with_bit;
    end
  end

  // ---------------------------------------------------------------
  // Octet output
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_octet      <= `OCT_ZERO;
      tx_octet_last <= 1'b0;
    end else if (take_bit && (octet_full || frame_end)) begin
      tx_octet      <= acc_with_bit;
      tx_octet_last <= frame_end;
    end
  end

  assign tx_octet_valid = (state_r == PACK_HOLD);

  // Index counts up within a frame and restarts after the last octet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idx_r          <= `IDX_ZERO;
      tx_octet_index <= `IDX_ZERO;
    end else if (take_bit && (octet_full || frame_end)) begin
      tx_octet_index <= idx_r;
      idx_r <= frame_end ? `IDX_ZERO : idx_r + `IDX_ONE;
    end
  end

  // ---------------------------------------------------------------
  // Alternation watch on the final 2400 bit
  // ---------------------------------------------------------------
  // Flags only; the coder owns the bit, so it is passed unchanged.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_prev_r <= 1'b0;
      sync_seen_r <= 1'b0;
      tx_sync_err <= 1'b0;
    end else begin
      tx_sync_err <= 1'b0;
      if (take_bit && frame_end && rate_cur == RATE_2400) begin
        sync_prev_r <= tx_bit;
        sync_seen_r <= 1'b1;
        tx_sync_err <= sync_seen_r && (tx_bit == sync_prev_r);
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------
  frame_unpacker u_unpacker (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .rx_rate_sel    (rx_rate_sel),
    .rx_octet       (rx_octet),
    .rx_octet_valid (rx_octet_valid),
    .rx_octet_ready (rx_octet_ready),
    .rx_bit         (rx_bit),
    .rx_bit_valid   (rx_bit_valid),
    .rx_bit_ready   (rx_bit_ready),
    .rx_bit_last    (rx_bit_last),
    .rx_frame_valid (rx_frame_valid),
    .rx_sync_err    (rx_sync_err)
  );
endmodule : vocoder_frame_octet_packer

// ==== sim/vocoder_frame_octet_packer_asserts.sv ====
// Port-level assertions for the vocoder frame octet packer
`timescale 1ns/1ps
`include "vocoder_frame_cfg.svh"
module vocoder_frame_octet_packer_asserts (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              tx_bit_ready,
  input wire logic [`OCT_W-1:0] tx_octet,
  input wire logic [`IDX_W-1:0] tx_octet_index,
  input wire logic              tx_octet_valid,
  input wire logic              tx_octet_ready,
  input wire logic              tx_octet_last,
  input wire logic              tx_sync_err,
  input wire logic              rx_octet_valid,
  input wire logic              rx_octet_ready,
  input wire logic              rx_bit_valid,
  input wire logic              rx_frame_valid
);
  logic [`IDX_W-1:0] next_idx_r;
  logic              pop;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  assign pop = tx_octet_valid && tx_octet_ready;

  // Index the next popped octet must carry; a new frame restarts at zero
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      next_idx_r <= 4'h0;
    else if (pop)
      next_idx_r <= tx_octet_last ? 4'h0 : tx_octet_index + 4'h1;
  end

  pad_zero_a: assert property (tx_octet_valid && tx_octet_last
    |-> tx_octet[7:6] == 2'h0) else $error("pad bits not zero");
  pad_long_a: assert property (tx_octet_valid && tx_octet_last
    && tx_octet_index == 4'hA |-> tx_octet[7:1] == 7'h00)
    else $error("long frame pad bits not zero");
  frame_len_a: assert property (tx_octet_valid && tx_octet_last
    |-> tx_octet_index == 4'h6 || tx_octet_index == 4'hA)
    else $error("frame octet count wrong");
  octet_hold_a: assert property (tx_octet_valid && !tx_octet_ready
    |=> tx_octet_valid && $stable(tx_octet) && $stable(tx_octet_index))
    else $error("octet changed before pop");
  octet_order_a: assert property (pop
    |-> tx_octet_index == next_idx_r) else $error("octet index out of order");
  bit_block_a: assert property (tx_octet_valid |-> !tx_bit_ready)
    else $error("bit taken while octet held");
  fv_pulse_a: assert property (rx_frame_valid |=> !rx_frame_valid)
    else $error("frame valid longer than one cycle");
  fv_bits_a: assert property (rx_frame_valid |-> rx_bit_valid)
    else $error("frame valid without bits");
  rx_shift_a: assert property (rx_octet_valid && rx_octet_ready
    |=> rx_bit_valid && !rx_octet_ready) else $error("octet not unpacked");
  sync_pulse_a: assert property (tx_sync_err |=> !tx_sync_err)
    else $error("sync flag stuck");

  cover property (pop && tx_octet_last && tx_octet_index == 4'h6);
  cover property (pop && tx_octet_last && tx_octet_index == 4'hA);
  cover property (tx_sync_err);
  cover property (rx_frame_valid);
endmodule : vocoder_frame_octet_packer_asserts

bind vocoder_frame_octet_packer vocoder_frame_octet_packer_asserts
  vocoder_frame_octet_packer_asserts_i (.core_clk, .rst_n, .tx_bit_ready,
  .tx_octet, .tx_octet_index, .tx_octet_valid, .tx_octet_ready,
  .tx_octet_last, .tx_sync_err, .rx_octet_valid, .rx_octet_ready,
  .rx_bit_valid, .rx_frame_valid);

// ==== sim/octet_transport_model.sv ====
// Packet transport model that loops sent octets back to the receiver
`timescale 1ns/1ps
module octet_transport_model (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] tx_octet,
  input  wire logic       tx_octet_valid,
  output logic            tx_octet_ready,
  input  wire logic       tx_octet_last,
  output logic [7:0]      rx_octet,
  output logic            rx_octet_valid,
  input  wire logic       rx_octet_ready,
  input  wire logic       slow,
  input  wire logic       junk
);
  logic busy;

  always @(posedge core_clk) begin
    busy = rx_octet_valid && !rx_octet_ready;
    if (!rst_n) begin
      rx_octet_valid <= 1'b0;
      rx_octet <= 8'h00;
    end else if (rx_octet_valid && rx_octet_ready) begin
      rx_octet_valid <= 1'b0;
      // A released line must not keep showing the old octet
      rx_octet <= ~rx_octet;
    end else if (tx_octet_valid && tx_octet_ready) begin
      // Octets pass in order; pads may be spoiled on request
      rx_octet <= tx_octet | ((junk && tx_octet_last) ? 8'hC0 : 8'h00);
      rx_octet_valid <= 1'b1;
      busy = 1'b1;
    end
    tx_octet_ready <= rst_n && !busy && !slow;
  end
endmodule : octet_transport_model

// ==== sim/vocoder_frame_octet_packer_test.sv ====
// Self-checking bench for the vocoder frame octet packer
`timescale 1ns/1ps
module vocoder_frame_octet_packer_test;
  import vocoder_frame_pkg::*;
  logic       core_clk, rst_n, tx_bit, tx_bit_valid, tx_bit_ready;
  logic       tx_octet_valid, tx_octet_ready, tx_octet_last, tx_sync_err;
  logic       rx_octet_valid, rx_octet_ready, rx_bit, rx_bit_valid;
  logic       rx_bit_ready, rx_bit_last, rx_frame_valid, rx_sync_err;
  logic       slow, junk;
  logic [7:0] tx_octet, rx_octet;
  logic [3:0] tx_octet_index;
  rate_type   tx_rate_sel, rx_rate_sel;
  integer     seed = 9309;
  int         fails, comparisons, frames, errs, fv_cnt, txe_cnt, rxe_cnt;
  int         rx_cnt, last_sync, stall, i;
  logic [12:0] oq[$];
  logic [1:0]  bq[$];
  rate_type    rq[$];

  vocoder_frame_octet_packer vocoder_frame_octet_packer_i (.core_clk,
    .rst_n, .tx_rate_sel, .tx_bit, .tx_bit_valid, .tx_bit_ready, .tx_octet,
    .tx_octet_index, .tx_octet_valid, .tx_octet_ready, .tx_octet_last,
    .tx_sync_err, .rx_rate_sel, .rx_octet, .rx_octet_valid, .rx_octet_ready,
    .rx_bit, .rx_bit_valid, .rx_bit_ready, .rx_bit_last, .rx_frame_valid,
    .rx_sync_err);
  octet_transport_model octet_transport_model_i (.core_clk, .rst_n,
    .tx_octet, .tx_octet_valid, .tx_octet_ready, .tx_octet_last, .rx_octet,
    .rx_octet_valid, .rx_octet_ready, .slow, .junk);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task check(input logic [12:0] seen, input logic [12:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Sends one frame; the model queues its octets and bits beforehand
  task send(input rate_type r, input int bad);
    int n, m, k;
    logic [7:0] o;
    logic b [0:87];
    n = (r == RATE_2400) ? 54 : 81;
    m = (n + 7) / 8 * 8;
    for (k = 0; k < n; k++) b[k] = 1'($random(seed));
    if (r == RATE_2400) begin
      if (last_sync >= 0) begin
        b[53] = bad ? last_sync[0] : !last_sync[0];
        errs += bad;
      end
      last_sync = int'(b[53]);
    end
    for (k = 0; k < m; k++) begin
      o[k % 8] = (k < n) ? b[k] : 1'b0;
      if (k % 8 == 7) oq.push_back({k == m - 1, 4'(k / 8), o});
    end
    for (k = 0; k < n; k++) bq.push_back({k == n - 1, b[k]});
    rq.push_back(r);
    frames++;
    for (k = 0; k < n; k++) begin
      tx_rate_sel <= r;
      tx_bit <= b[k];
      tx_bit_valid <= 1'b1;
      do @(posedge core_clk); while (tx_bit_ready !== 1'b1);
    end
  endtask : send

  always @(posedge core_clk) begin
    if (rst_n === 1'b1) begin
      {slow, rx_bit_ready} <= stall ? 2'($random(seed)) : 2'b01;
      if (tx_octet_valid && tx_octet_ready)
        check({tx_octet_last, tx_octet_index, tx_octet},
              oq.pop_front());
      if (rx_bit_valid && rx_bit_ready)
        check({rx_bit_last, rx_bit}, 13'(bq.pop_front()));
      if (rx_octet_valid && rx_octet_ready) begin
        rx_cnt++;
        if (rx_cnt == ((rq[0] == RATE_2400) ? 7 : 11)) begin
          rx_cnt = 0;
          void'(rq.pop_front());
        end
      end
      rx_rate_sel <= (rq.size() > 0) ? rq[0] : RATE_2400;
      fv_cnt += int'(rx_frame_valid);
      txe_cnt += int'(tx_sync_err);
      rxe_cnt += int'(rx_sync_err);
    end
  end

  initial begin
    #300000;
    fails++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    tx_bit = 1'b0;
    tx_bit_valid = 1'b0;
    tx_rate_sel = RATE_2400;
    rx_rate_sel = RATE_2400;
    rx_bit_ready = 1'b1;
    slow = 1'b0;
    junk = 1'b0;
    last_sync = -1;
    stall = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1 check({tx_bit_ready, tx_octet_valid, rx_octet_ready,
              rx_bit_valid, rx_frame_valid}, 13'h14);
    @(posedge core_clk);
    // Back-to-back frames, rate change, then a repeated sync bit
    send(RATE_2400, 0);
    send(RATE_2400, 0);
    send(RATE_1200, 0);
    send(RATE_2400, 1);
    stall <= 1;
    junk <= 1'b1;
    for (i = 0; i < 8; i++)
      send(rate_type'(1'($random(seed))), i == 5);
    tx_bit_valid <= 1'b0;
    repeat (3000) if (oq.size() + bq.size() > 0) @(posedge core_clk);
    repeat (5) @(posedge core_clk);
    check(13'(oq.size() + bq.size()), 13'h0);
    check(13'(fv_cnt), 13'(frames));
    check(13'(txe_cnt), 13'(errs));
    check(13'(rxe_cnt), 13'(errs));
    results();
  end
endmodule : vocoder_frame_octet_packer_test
